// file: src/lac_clk_tick.v
`timescale 1ns/1ns
`include "lac_defines.vh"

// turns the selected flip-flop clock source into a one-cycle tick
module lac_clk_tick (
    input wire clock_i,
    input wire resetn_i,
    input wire [2:0] sel_i,
    input wire [2:0] pin_sync_i,
    input wire xtal_sync_i,
    input wire tmr1_ovf_i,
    output reg tick_o
);

reg src_d;
reg src_q;

// ----------------------------------------------------------------------
// source selection
// ----------------------------------------------------------------------
// pick the level of the chosen source, reserved codes give a quiet source
always @* begin
    case (sel_i)
        `LAC_CLK_PIN0: src_d = pin_sync_i[0];
        `LAC_CLK_PIN1: src_d = pin_sync_i[1];
        `LAC_CLK_PIN2: src_d = pin_sync_i[2];
        `LAC_CLK_XTAL: src_d = xtal_sync_i;
        `LAC_CLK_TMR1: src_d = tmr1_ovf_i;
        default: src_d = 1'b0;
    endcase
end

// ----------------------------------------------------------------------
// edge to tick
// ----------------------------------------------------------------------
// core clock ticks every cycle, other sources tick on a rising edge
always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
        src_q <= 1'b0;
        tick_o <= 1'b0;
    end else begin
        src_q <= src_d;
        if (sel_i == `LAC_CLK_CORE) begin
            tick_o <= 1'b1;
        end else begin
            tick_o <= src_d & ~src_q;
        end
    end
end

endmodule // lac_clk_tick

// file: src/lac_control.v
`timescale 1ns/1ns
`include "lac_defines.vh"

// Contract
// R01: second group clock source select field
// R02: first group clock source select field
// R03: pin clocks stay below maximum rate
// R04: enabled second interrupt follows chosen element
// R05: enabled first interrupt follows chosen element
// R06: enabled conversion start follows chosen element
// R07: software input word feeds element inputs
// R08: output word shows element outputs
// R09: output word always live on read
// R10: lock bit accepts one write only
// R11: lock blocks configuration writes, input stays
// R12: input select takes word or feedback
// R13: lock holds until device reset
module lac_control #(
    parameter ELEMS = 16
) (
    input wire clock_i,
    input wire resetn_i,
    input wire [31:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output reg [31:0] rdata_o,
    input wire [ELEMS-1:0] element_out_i,
    input wire [ELEMS-1:0] input_mux_ctrl_i,
    input wire [ELEMS-1:0] feedback_mux_out_i,
    input wire [2:0] clk_pin_i,
    input wire crystal_clock_32k_i,
    input wire timer1_overflow_i,
    output reg [ELEMS-1:0] element_input_sel_o,
    output reg [ELEMS-1:0] sw_input_word_o,
    output reg [2:0] block0_clk_sel_o,
    output reg [2:0] block1_clk_sel_o,
    output wire block0_ff_tick_o,
    output wire block1_ff_tick_o,
    output reg array_interrupt_out_a_o,
    output reg array_interrupt_out_b_o,
    output reg converter_start_conversion_o,
    output reg config_locked_o,
    output reg irq_o
);

// ----------------------------------------------------------------------
// declarations
// ----------------------------------------------------------------------
reg [3:0] async_meta_q;
reg [3:0] async_sync_q;
reg [3:0] irqa_src_q;
reg irqa_en_q;
reg [3:0] irqb_src_q;
reg irqb_en_q;
reg [3:0] conv_src_q;
reg conv_en_q;
reg lock_written_q;
reg [`LAC_EVT_W-1:0] evt_status_q;
reg [`LAC_EVT_W-1:0] evt_status_d;
reg [`LAC_EVT_W-1:0] evt_mask_q;
reg [`LAC_EVT_W-1:0] evt_set;
reg [31:0] rdata_d;
reg irqa_d;
reg irqb_d;
reg conv_d;
wire cfg_wr_ok;
wire wr_clk;
wire wr_irq;
wire wr_conv;
wire wr_din;
wire wr_lock;
wire wr_stat;
wire wr_mask;

// ----------------------------------------------------------------------
// helpers
// ----------------------------------------------------------------------
// pick one element output by its four-bit index
function elem_pick;
    input [15:0] vec;
    input [3:0] idx;
    begin
        elem_pick = vec[idx];
    end
endfunction

// true when the bus address hits a given register
function hit;
    input [31:0] a;
    input [31:0] reg_addr;
    begin
        hit = (a == reg_addr);
    end
endfunction

// ----------------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------------
// two flops for the pin clocks and the crystal clock
// R03: pin clocks sampled
// the far side keeps pin clocks far below the core rate, so no edge is lost
always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
        async_meta_q <= 4'h0;
        async_sync_q <= 4'h0;
    end else begin
        async_meta_q <= {crystal_clock_32k_i, clk_pin_i};
        async_sync_q <= async_meta_q;
    end
end

// ----------------------------------------------------------------------
// flip-flop clock ticks
// ----------------------------------------------------------------------
// R02: first group clock
lac_clk_tick u_tick_block0 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .sel_i(block0_clk_sel_o),
    .pin_sync_i(async_sync_q[2:0]),
    .xtal_sync_i(async_sync_q[3]),
    .tmr1_ovf_i(timer1_overflow_i),
    .tick_o(block0_ff_tick_o)
);

// R01: second group clock
lac_clk_tick u_tick_block1 (
    .clock_i(clock_i),
    .resetn_i(resetn_i),
    .sel_i(block1_clk_sel_o),
    .pin_sync_i(async_sync_q[2:0]),
    .xtal_sync_i(async_sync_q[3]),
    .tmr1_ovf_i(timer1_overflow_i),
    .tick_o(block1_ff_tick_o)
);

// ----------------------------------------------------------------------
// write decode
// ----------------------------------------------------------------------
// R11: lock gates configuration
assign cfg_wr_ok = wr_i & ~config_locked_o;
assign wr_clk = cfg_wr_ok & hit(addr_i, `LAC_ADDR_CLK_SEL);
assign wr_irq = cfg_wr_ok & hit(addr_i, `LAC_ADDR_IRQ_ROUTE);
assign wr_conv = cfg_wr_ok & hit(addr_i, `LAC_ADDR_CONV_ROUTE);
assign wr_lock = wr_i & hit(addr_i, `LAC_ADDR_LOCK);
// software input word stays writable while locked
assign wr_din = wr_i & hit(addr_i, `LAC_ADDR_SW_INPUT);
assign wr_stat = wr_i & hit(addr_i, `LAC_ADDR_EVT_STATUS);
assign wr_mask = wr_i & hit(addr_i, `LAC_ADDR_EVT_MASK);

// ----------------------------------------------------------------------
// configuration registers
// ----------------------------------------------------------------------
// clock selects and routing fields
always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
        block0_clk_sel_o <= `LAC_RST_CLK_SEL;
        block1_clk_sel_o <= `LAC_RST_CLK_SEL;
        irqa_src_q <= `LAC_RST_SRC;
        irqa_en_q <= 1'b0;
        irqb_src_q <= `LAC_RST_SRC;
        irqb_en_q <= 1'b0;
        conv_src_q <= `LAC_RST_SRC;
        conv_en_q <= 1'b0;
    end else begin
        // R01: second group field
        if (wr_clk) begin
            block1_clk_sel_o <= wdata_i[`LAC_CLK_B1_MSB:`LAC_CLK_B1_LSB];
        end
        // R02: first group field
        if (wr_clk) begin
            block0_clk_sel_o <= wdata_i[`LAC_CLK_B0_MSB:`LAC_CLK_B0_LSB];
        end
        if (wr_irq) begin
            irqa_src_q <= wdata_i[`LAC_IRQA_SRC_MSB:`LAC_IRQA_SRC_LSB];
            irqa_en_q <= wdata_i[`LAC_IRQA_EN_BIT];
            irqb_src_q <= wdata_i[`LAC_IRQB_SRC_MSB:`LAC_IRQB_SRC_LSB];
            irqb_en_q <= wdata_i[`LAC_IRQB_EN_BIT];
        end
        if (wr_conv) begin
            conv_src_q <= wdata_i[`LAC_CONV_SRC_MSB:`LAC_CONV_SRC_LSB];
            conv_en_q <= wdata_i[`LAC_CONV_EN_BIT];
        end
    end
end

// ----------------------------------------------------------------------
// software input word
// ----------------------------------------------------------------------
// R07: input word store
always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
        sw_input_word_o <= `LAC_RST_WORD16;
    end else if (wr_din) begin
        sw_input_word_o <= wdata_i[ELEMS-1:0];
    end
end

// ----------------------------------------------------------------------
// element input select
// ----------------------------------------------------------------------
// R12: word or feedback
always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
        element_input_sel_o <= `LAC_RST_WORD16;
    end else begin
        element_input_sel_o <= (input_mux_ctrl_i & feedback_mux_out_i)
            | (~input_mux_ctrl_i & sw_input_word_o);
    end
end

// ----------------------------------------------------------------------
// lock
// ----------------------------------------------------------------------
// only the first lock write counts, cleared only by reset
always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
        // R13: reset unlocks
        lock_written_q <= 1'b0;
        config_locked_o <= 1'b0;
    end else begin
        // R10: single write
        if (wr_lock && !lock_written_q) begin
            lock_written_q <= 1'b1;
            config_locked_o <= wdata_i[`LAC_LOCK_BIT];
        end
    end
end

// ----------------------------------------------------------------------
// routing of element outputs
// ----------------------------------------------------------------------
// next values of the routed lines
always @* begin
    // R05: first interrupt route
    irqa_d = irqa_en_q & elem_pick(element_out_i, irqa_src_q);
    // R04: second interrupt route
    irqb_d = irqb_en_q & elem_pick(element_out_i, irqb_src_q);
    // R06: conversion start route
    conv_d = conv_en_q & elem_pick(element_out_i, conv_src_q);
end

// registered routed outputs, low while disabled
always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
        array_interrupt_out_a_o <= 1'b0;
        array_interrupt_out_b_o <= 1'b0;
        converter_start_conversion_o <= 1'b0;
    end else begin
        array_interrupt_out_a_o <= irqa_d;
        array_interrupt_out_b_o <= irqb_d;
        converter_start_conversion_o <= conv_d;
    end
end

// ----------------------------------------------------------------------
// event status and interrupt
// ----------------------------------------------------------------------
// rising edges of the routed lines set sticky bits, set beats clear
always @* begin
    evt_set = {`LAC_EVT_W{1'b0}};
    evt_set[`LAC_EVT_IRQA] = irqa_d & ~array_interrupt_out_a_o;
    evt_set[`LAC_EVT_IRQB] = irqb_d & ~array_interrupt_out_b_o;
    evt_set[`LAC_EVT_CONV] = conv_d & ~converter_start_conversion_o;
    evt_status_d = evt_status_q;
    if (wr_stat) begin
        evt_status_d = evt_status_d & ~wdata_i[`LAC_EVT_W-1:0];
    end
    evt_status_d = evt_status_d | evt_set;
end

// status, mask and level interrupt
always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
        evt_status_q <= `LAC_RST_EVT;
        evt_mask_q <= `LAC_RST_EVT;
        irq_o <= 1'b0;
    end else begin
        evt_status_q <= evt_status_d;
        if (wr_mask) begin
            evt_mask_q <= wdata_i[`LAC_EVT_W-1:0];
        end
        irq_o <= |(evt_status_q & evt_mask_q);
    end
end

// ----------------------------------------------------------------------
// read path
// ----------------------------------------------------------------------
// read data mux, reserved and unmapped read as zero
always @* begin
    rdata_d = 32'h00000000;
    case (addr_i)
        `LAC_ADDR_CLK_SEL: begin
            rdata_d[`LAC_CLK_B1_MSB:`LAC_CLK_B1_LSB] = block1_clk_sel_o;
            rdata_d[`LAC_CLK_B0_MSB:`LAC_CLK_B0_LSB] = block0_clk_sel_o;
        end
        `LAC_ADDR_IRQ_ROUTE: begin
            rdata_d[`LAC_IRQB_EN_BIT] = irqb_en_q;
            rdata_d[`LAC_IRQB_SRC_MSB:`LAC_IRQB_SRC_LSB] = irqb_src_q;
            rdata_d[`LAC_IRQA_EN_BIT] = irqa_en_q;
            rdata_d[`LAC_IRQA_SRC_MSB:`LAC_IRQA_SRC_LSB] = irqa_src_q;
        end
        `LAC_ADDR_CONV_ROUTE: begin
            rdata_d[`LAC_CONV_EN_BIT] = conv_en_q;
            rdata_d[`LAC_CONV_SRC_MSB:`LAC_CONV_SRC_LSB] = conv_src_q;
        end
        `LAC_ADDR_SW_INPUT: begin
            rdata_d[ELEMS-1:0] = sw_input_word_o;
        end
        // R08: output word read
        `LAC_ADDR_OUT_WORD: begin
            // R09: always live
            rdata_d[ELEMS-1:0] = element_out_i;
        end
        `LAC_ADDR_EVT_STATUS: begin
            rdata_d[`LAC_EVT_W-1:0] = evt_status_q;
        end
        `LAC_ADDR_EVT_MASK: begin
            rdata_d[`LAC_EVT_W-1:0] = evt_mask_q;
        end
        default: begin
            rdata_d = 32'h00000000;
        end
    endcase
end

// read data stand only in the cycle after the read strobe
always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
        rdata_o <= 32'h00000000;
    end else if (rd_i) begin
        rdata_o <= rdata_d;
    end else begin
        rdata_o <= 32'h00000000;
    end
end

endmodule // lac_control

// file: src/lac_defines.vh
`ifndef LAC_DEFINES_VH
`define LAC_DEFINES_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define LAC_ADDR_CLK_SEL 32'hFFFF0B40
`define LAC_ADDR_IRQ_ROUTE 32'hFFFF0B44
`define LAC_ADDR_CONV_ROUTE 32'hFFFF0B48
`define LAC_ADDR_SW_INPUT 32'hFFFF0B4C
`define LAC_ADDR_OUT_WORD 32'hFFFF0B50
`define LAC_ADDR_LOCK 32'hFFFF0B54
`define LAC_ADDR_EVT_STATUS 32'hFFFF0B58
`define LAC_ADDR_EVT_MASK 32'hFFFF0B5C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define LAC_CLK_B0_LSB 0
`define LAC_CLK_B0_MSB 2
`define LAC_CLK_B1_LSB 4
`define LAC_CLK_B1_MSB 6
`define LAC_IRQA_SRC_LSB 0
`define LAC_IRQA_SRC_MSB 3
`define LAC_IRQA_EN_BIT 4
`define LAC_IRQB_SRC_LSB 8
`define LAC_IRQB_SRC_MSB 11
`define LAC_IRQB_EN_BIT 12
`define LAC_CONV_SRC_LSB 0
`define LAC_CONV_SRC_MSB 3
`define LAC_CONV_EN_BIT 4
`define LAC_LOCK_BIT 0
`define LAC_ELEM_MSB 15

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define LAC_RST_CLK_SEL 3'h0
`define LAC_RST_SRC 4'h0
`define LAC_RST_WORD16 16'h0000
`define LAC_RST_EVT 3'h0

// ----------------------------------------------------------------------
// clock source codes
// ----------------------------------------------------------------------
`define LAC_CLK_PIN0 3'h0
`define LAC_CLK_PIN1 3'h1
`define LAC_CLK_PIN2 3'h2
`define LAC_CLK_CORE 3'h3
`define LAC_CLK_XTAL 3'h4
`define LAC_CLK_TMR1 3'h5

// ----------------------------------------------------------------------
// event status bits
// ----------------------------------------------------------------------
`define LAC_EVT_W 3
`define LAC_EVT_IRQA 0
`define LAC_EVT_IRQB 1
`define LAC_EVT_CONV 2

// highest pin clock rate the far side may apply, in kHz
`define LAC_PIN_CLK_MAX_KHZ 41780

`endif

// file: verification/lac_array_model.sv
`timescale 1ns/1ns

// ----
// element array standing beside the control block
// ----
module lac_array_model (
    input wire clock_i,
    input wire resetn_i,
    input wire [15:0] elem_i,
    input wire [31:0] rnd_i,
    output reg [15:0] element_out_o,
    output reg [15:0] input_mux_ctrl_o,
    output reg [15:0] feedback_mux_out_o,
    output wire [2:0] clk_pin_o,
    output wire crystal_clock_32k_o
);
    reg [7:0] div_q;
    // elements settle one cycle after the wanted word, selects wander
    always @(posedge clock_i or negedge resetn_i) begin
        if (!resetn_i) begin
            element_out_o <= 16'h0000;
            input_mux_ctrl_o <= 16'h0000;
            feedback_mux_out_o <= 16'h0000;
            div_q <= 8'h00;
        end else begin
            element_out_o <= elem_i;
            input_mux_ctrl_o <= rnd_i[15:0];
            feedback_mux_out_o <= rnd_i[31:16];
            div_q <= div_q + 8'h01;
        end
    end
    assign clk_pin_o = div_q[3:1];
    assign crystal_clock_32k_o = div_q[7];
endmodule // lac_array_model

// file: verification/lac_control_chk.sv
`timescale 1ns/1ns
`include "lac_defines.vh"

// port-level checks of the control block
module lac_control_chk #(
    parameter ELEMS = 16
) (
    input wire clock_i,
    input wire resetn_i,
    input wire [31:0] addr_i,
    input wire [31:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    input wire [31:0] rdata_o,
    input wire [ELEMS-1:0] element_out_i,
    input wire [ELEMS-1:0] input_mux_ctrl_i,
    input wire [ELEMS-1:0] feedback_mux_out_i,
    input wire [ELEMS-1:0] element_input_sel_o,
    input wire [ELEMS-1:0] sw_input_word_o,
    input wire [2:0] block0_clk_sel_o,
    input wire [2:0] block1_clk_sel_o,
    input wire block0_ff_tick_o,
    input wire block1_ff_tick_o,
    input wire array_interrupt_out_a_o,
    input wire array_interrupt_out_b_o,
    input wire converter_start_conversion_o,
    input wire config_locked_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    outword_live_a: assert property (rd_i && addr_i == `LAC_ADDR_OUT_WORD |=>
        rdata_o == {16'h0000, $past(element_out_i)}) else $error("output word stale");
    lock_readzero_a: assert property (rd_i && addr_i == `LAC_ADDR_LOCK |=>
        rdata_o == 32'h0) else $error("lock register readable");
    insel_mix_a: assert property ($past(resetn_i) |-> element_input_sel_o ==
        $past(input_mux_ctrl_i & feedback_mux_out_i | ~input_mux_ctrl_i & sw_input_word_o))
        else $error("input select mix wrong");
    swword_write_a: assert property (wr_i && addr_i == `LAC_ADDR_SW_INPUT |=>
        sw_input_word_o == $past(wdata_i[15:0])) else $error("input word write lost");
    clksel_write_a: assert property (!config_locked_o && wr_i && addr_i == `LAC_ADDR_CLK_SEL
        |=> block1_clk_sel_o == $past(wdata_i[6:4]) && block0_clk_sel_o == $past(wdata_i[2:0]))
        else $error("clock select write lost");
    locked_freeze_a: assert property (config_locked_o |=> $stable(block0_clk_sel_o) &&
        $stable(block1_clk_sel_o)) else $error("clock select changed while locked");
    lock_sticky_a: assert property (config_locked_o |=> config_locked_o)
        else $error("lock dropped");
    route_quiet_a: assert property ($past(resetn_i) && $past(element_out_i) == 0 |->
        !array_interrupt_out_a_o && !array_interrupt_out_b_o && !converter_start_conversion_o)
        else $error("routed line high with idle elements");
    core_tick_a: assert property ((block0_clk_sel_o == 3'h3) [*2] |-> block0_ff_tick_o)
        else $error("core clock tick missing");
    reserved_tick_a: assert property ((block1_clk_sel_o[2:1] == 2'b11) [*2] |->
        !block1_ff_tick_o) else $error("tick from reserved code");

    lock_seen_c: cover property ($rose(config_locked_o));
    conv_seen_c: cover property ($rose(converter_start_conversion_o));
    tick_seen_c: cover property (block1_clk_sel_o == 3'h5 && block1_ff_tick_o);
endmodule // lac_control_chk

// file: verification/tb.sv
`timescale 1ns/1ns
`include "lac_defines.vh"

module tb;
    reg clock_i, resetn_i, wr_i, rd_i, timer1_overflow_i, rd_q;
    reg [31:0] addr_i, wdata_i, seed, rnd, dat;
    reg [15:0] elem;
    reg [31:0] expq[$];
    wire [31:0] rdata_o;
    wire [15:0] element_out_i, input_mux_ctrl_i, feedback_mux_out_i;
    wire [2:0] clk_pin_i;
    wire crystal_clock_32k_i, ia, ib, cv, lk, irq, t1;
    integer err_count, check_count, cyc, i, n;

    lac_control #(.ELEMS(16)) dut (
        .clock_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .element_out_i, .input_mux_ctrl_i, .feedback_mux_out_i, .clk_pin_i,
        .crystal_clock_32k_i, .timer1_overflow_i, .element_input_sel_o(),
        .sw_input_word_o(), .block0_clk_sel_o(), .block1_clk_sel_o(),
        .block0_ff_tick_o(), .block1_ff_tick_o(t1), .array_interrupt_out_a_o(ia),
        .array_interrupt_out_b_o(ib), .converter_start_conversion_o(cv),
        .config_locked_o(lk), .irq_o(irq)
    );
    lac_array_model u_far (
        .clock_i, .resetn_i, .elem_i(elem), .rnd_i(rnd), .element_out_o(element_out_i),
        .input_mux_ctrl_o(input_mux_ctrl_i), .feedback_mux_out_o(feedback_mux_out_i),
        .clk_pin_o(clk_pin_i), .crystal_clock_32k_o(crystal_clock_32k_i)
    );

    // ----
    // shared tasks
    // ----
    task check(input [31:0] got, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("Error at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask
    task wr(input [31:0] a, input [31:0] d);
        begin
            addr_i <= a;
            wdata_i <= d;
            wr_i <= 1'b1;
            rd_i <= 1'b0;
            @(posedge clock_i);
        end
    endtask
    task rd(input [31:0] a, input [31:0] e);
        begin
            expq.push_back(e);
            addr_i <= a;
            rd_i <= 1'b1;
            wr_i <= 1'b0;
            @(posedge clock_i);
        end
    endtask
    task idle(input integer k);
        begin
            wr_i <= 1'b0;
            rd_i <= 1'b0;
            repeat (k) @(posedge clock_i);
        end
    endtask
    task stop_test;
        begin
            $display("errors %0d checks %0d", err_count, check_count);
            if (err_count == 0 && check_count > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask

    // clock
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    // read data compared in the cycle after each read
    always @(negedge clock_i) begin
        if (rd_q)
            check(rdata_o, expq.pop_front());
        rd_q = rd_i;
    end
    // random selects for the far side, and the hang limit
    always @(posedge clock_i) begin
        rnd <= $random(seed);
        cyc = cyc + 1;
        if (cyc == 5000) begin
            err_count = err_count + 1;
            stop_test;
        end
    end

    // ----
    // main sequence
    // ----
    initial begin
        seed = 32'hE8D766D5;
        {err_count, check_count, cyc, n} = 0;
        {wr_i, rd_i, timer1_overflow_i} = 3'h0;
        {addr_i, wdata_i} = 64'h0;
        elem = 16'h0000;
        resetn_i = 1'b0;
        repeat (2) @(posedge clock_i);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        for (i = 0; i < 9; i = i + 1)
            rd(`LAC_ADDR_CLK_SEL + 4 * i, 32'h0);
        dat = $random(seed);
        wr(`LAC_ADDR_CLK_SEL, dat);
        rd(`LAC_ADDR_CLK_SEL, dat & 32'h77);
        wr(`LAC_ADDR_IRQ_ROUTE, dat);
        rd(`LAC_ADDR_IRQ_ROUTE, dat & 32'h1F1F);
        wr(`LAC_ADDR_CONV_ROUTE, dat);
        rd(`LAC_ADDR_CONV_ROUTE, dat & 32'h1F);
        wr(`LAC_ADDR_SW_INPUT, dat);
        rd(`LAC_ADDR_SW_INPUT, dat & 32'hFFFF);
        wr(`LAC_ADDR_OUT_WORD, dat);
        rd(`LAC_ADDR_OUT_WORD, 32'h0);
        // every element routed to the first interrupt and conversion lines in turn, only odd elements to the second
        for (i = 0; i < 16; i = i + 1) begin
            wr(`LAC_ADDR_IRQ_ROUTE, 32'h1010 | i | ((i[0] ? i : 15 - i) << 8));
            wr(`LAC_ADDR_CONV_ROUTE, 32'h10 | i);
            elem <= 16'h1 << i;
            idle(3);
            check({ib, ia, cv}, {i[0], 2'b11});
            rd(`LAC_ADDR_OUT_WORD, 32'h1 << i);
        end
        wr(`LAC_ADDR_IRQ_ROUTE, 32'h0);
        wr(`LAC_ADDR_CONV_ROUTE, 32'h0);
        idle(3);
        check({ib, ia, cv}, 32'h0);
        // events raise, mask and clear the interrupt
        rd(`LAC_ADDR_EVT_STATUS, 32'h7);
        idle(1);
        check(irq, 32'h0);
        wr(`LAC_ADDR_EVT_MASK, 32'h1);
        idle(2);
        check(irq, 32'h1);
        wr(`LAC_ADDR_EVT_STATUS, 32'h1);
        idle(2);
        check(irq, 32'h0);
        rd(`LAC_ADDR_EVT_STATUS, 32'h6);
        // lock freezes configuration but not the input word
        wr(`LAC_ADDR_CLK_SEL, 32'h53);
        wr(`LAC_ADDR_LOCK, 32'h1);
        wr(`LAC_ADDR_LOCK, 32'h0);
        wr(`LAC_ADDR_CLK_SEL, 32'h11);
        wr(`LAC_ADDR_IRQ_ROUTE, 32'h1F1F);
        wr(`LAC_ADDR_SW_INPUT, 32'hA5A5);
        rd(`LAC_ADDR_CLK_SEL, 32'h53);
        rd(`LAC_ADDR_IRQ_ROUTE, 32'h0);
        rd(`LAC_ADDR_SW_INPUT, 32'hA5A5);
        rd(`LAC_ADDR_LOCK, 32'h0);
        idle(1);
        check(lk, 32'h1);
        // one timer overflow gives one tick to the second group
        timer1_overflow_i <= 1'b1;
        idle(1);
        timer1_overflow_i <= 1'b0;
        repeat (6) begin
            @(negedge clock_i);
            n = n + t1;
        end
        check(n, 32'h1);
        @(posedge clock_i);
        // reset lifts the lock
        resetn_i <= 1'b0;
        idle(2);
        resetn_i <= 1'b1;
        idle(1);
        check(lk, 32'h0);
        // second group on the middle pin clock gives two ticks in sixteen cycles
        wr(`LAC_ADDR_CLK_SEL, 32'h14);
        idle(4);
        n = 0;
        repeat (16) begin
            @(negedge clock_i);
            n = n + t1;
        end
        check(n, 32'h2);
        @(posedge clock_i);
        // reserved code on the second group, accepted again after reset
        wr(`LAC_ADDR_CLK_SEL, 32'h62);
        rd(`LAC_ADDR_CLK_SEL, 32'h62);
        idle(3);
        stop_test;
    end
endmodule // tb

bind lac_control lac_control_chk #(.ELEMS(ELEMS)) u_chk (
    .clock_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .element_out_i,
    .input_mux_ctrl_i, .feedback_mux_out_i, .element_input_sel_o, .sw_input_word_o,
    .block0_clk_sel_o, .block1_clk_sel_o, .block0_ff_tick_o, .block1_ff_tick_o,
    .array_interrupt_out_a_o, .array_interrupt_out_b_o, .converter_start_conversion_o,
    .config_locked_o
);
